/* rtl/pgm_top.sv */
// Pad GPIO and signal monitor block: registers, pad control, monitor pin.
// Assumes a 40 MHz clock, synchronous pad inputs, plain register port.
//
// Contract
// - Enable bit 7 turns the aux input pin into a driven output.
// - Enable bit 6 replaces the clock output with a GPIO output.
// - Enable bits 5 and 4 turn the interface-select pins into outputs.
// - Enable bits 3 to 0 turn TCK, TMS, TDI and TDO into outputs.
// - With boundary scan on, the four scan pin enables are ignored.
// - Each output-value bit drives its pin, same order as enables.
// - The input register returns each pin's current input level.
// - Signal-output bit 7 selects fast pad switching.
// - Monitor codes 0h and 1h leave the monitor pin tri-stated.
// - Codes 2h and 3h drive constant 0 and constant 1.
// - Codes 4h and 5h show transmit envelope and transmit active.
// - Code 6h shows the secure-module serial signal.
// - Code 7h shows the receive envelope, meaningful at 106 kBd type A.
// - Codes 8h and 9h show receive active and the received bits.
module pgm_top (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Register port
  input  wire logic [7:0] i_addr,
  input  wire logic [7:0] i_wdata,
  input  wire logic       i_wr,
  input  wire logic       i_rd,
  output logic      [7:0] o_rdata,
  // Device state
  input  wire logic       i_scan_active,
  // Alternate pad functions (clock out, scan outputs)
  input  wire logic [7:0] i_func_out,
  input  wire logic [7:0] i_func_oe,
  // Monitor sources
  input  wire logic       i_tx_envelope,
  input  wire logic       i_tx_active,
  input  wire logic       i_secure_module_serial_signal,
  input  wire logic       i_rx_envelope,
  input  wire logic       i_rx_active,
  input  wire logic       i_rx_bit,
  // Multi-purpose pads
  input  wire logic [7:0] i_pad_in,
  output logic      [7:0] o_pad_out,
  output logic      [7:0] o_pad_oe,
  // Monitor pin and pad speed
  output logic            o_monitor_output_pin,
  output logic            o_monitor_output_pin_oe,
  output logic            o_fast_pad_switching
);

  logic [7:0] pad_output_enable_reg;
  logic [7:0] pad_output_enable_next;
  logic [7:0] pad_output_value_reg;
  logic [7:0] pad_output_value_next;
  logic [7:0] signal_output_select_reg;
  logic [7:0] signal_output_select_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;
  logic [3:0] monitor_source_select;

  // Register writes; reserved bits 6..4 of signal output stay zero
  always_comb begin
    pad_output_enable_next    = pad_output_enable_reg;
    pad_output_value_next     = pad_output_value_reg;
    signal_output_select_next = signal_output_select_reg;
    if (i_wr) begin
      unique case (i_addr)
        pgm_pkg::PGM_OFS_PAD_EN:  pad_output_enable_next = i_wdata;
        pgm_pkg::PGM_OFS_PAD_OUT: pad_output_value_next  = i_wdata;
        pgm_pkg::PGM_OFS_SIG_OUT: signal_output_select_next =
          i_wdata & 8'h8f;
        default: ;
      endcase
    end
  end

  // Read data, valid the cycle after the strobe only
  always_comb begin
    rdata_next = 8'h00;
    if (i_rd) begin
      unique case (i_addr)
        pgm_pkg::PGM_OFS_PAD_EN:  rdata_next = pad_output_enable_reg;
        pgm_pkg::PGM_OFS_PAD_OUT: rdata_next = pad_output_value_reg;
        pgm_pkg::PGM_OFS_PAD_IN:  rdata_next = i_pad_in;
        pgm_pkg::PGM_OFS_SIG_OUT: rdata_next = signal_output_select_reg;
        default:                  rdata_next = 8'h00;
      endcase
    end
  end

  // Register state
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      pad_output_enable_reg    <= pgm_pkg::PGM_RST_PAD_EN;
      pad_output_value_reg     <= pgm_pkg::PGM_RST_PAD_OUT;
      signal_output_select_reg <= pgm_pkg::PGM_RST_SIG_OUT;
      rdata_reg                <= 8'h00;
    end else begin
      pad_output_enable_reg    <= pad_output_enable_next;
      pad_output_value_reg     <= pad_output_value_next;
      signal_output_select_reg <= signal_output_select_next;
      rdata_reg                <= rdata_next;
    end
  end

  assign o_rdata = rdata_reg;

  assign o_fast_pad_switching =
    signal_output_select_reg[pgm_pkg::PGM_BIT_FAST];

  // Monitor source field of the signal-output register
  assign monitor_source_select =
    signal_output_select_reg[pgm_pkg::PGM_SEL_MSB:pgm_pkg::PGM_SEL_LSB];

  // Pad drive control
  pgm_pad_cell u_pads (
    .i_clk         (i_clk),
    .i_reset       (i_reset),
    .i_enable      (pad_output_enable_reg),
    .i_value       (pad_output_value_reg),
    .i_scan_active (i_scan_active),
    .i_func_out    (i_func_out),
    .i_func_oe     (i_func_oe),
    .o_pad_out     (o_pad_out),
    .o_pad_oe      (o_pad_oe)
  );

  // Monitor pin selector
  pgm_monitor_mux u_mon (
    .i_clk                         (i_clk),
    .i_reset                       (i_reset),
    .i_sel                         (monitor_source_select),
    .i_tx_envelope                 (i_tx_envelope),
    .i_tx_active                   (i_tx_active),
    .i_secure_module_serial_signal (i_secure_module_serial_signal),
    .i_rx_envelope                 (i_rx_envelope),
    .i_rx_active                   (i_rx_active),
    .i_rx_bit                      (i_rx_bit),
    .o_out                         (o_monitor_output_pin),
    .o_oe                          (o_monitor_output_pin_oe)
  );

endmodule

/* rtl/pgm_pkg.sv */
// Package for the pad GPIO and signal monitor multiplexer.
// Assumes a single 40 MHz clock domain and a plain register port.
package pgm_pkg;

  // Register offsets
  localparam logic [7:0] PGM_OFS_PAD_EN  = 8'h44;
  localparam logic [7:0] PGM_OFS_PAD_OUT = 8'h45;
  localparam logic [7:0] PGM_OFS_PAD_IN  = 8'h46;
  localparam logic [7:0] PGM_OFS_SIG_OUT = 8'h47;

  // Reset values
  localparam logic [7:0] PGM_RST_PAD_EN  = 8'h00;
  localparam logic [7:0] PGM_RST_PAD_OUT = 8'h00;
  localparam logic [7:0] PGM_RST_SIG_OUT = 8'h00;

  // Pad bit positions, shared by enable, value and input registers
  localparam int PGM_BIT_AUX_IN  = 7;
  localparam int PGM_BIT_CLK     = 6;
  localparam int PGM_BIT_HOST_IF_SEL_1 = 5;
  localparam int PGM_BIT_HOST_IF_SEL_0 = 4;
  localparam int PGM_BIT_TCK     = 3;
  localparam int PGM_BIT_TMS     = 2;
  localparam int PGM_BIT_TDI     = 1;
  localparam int PGM_BIT_TDO     = 0;
  localparam int PGM_NUM_PADS    = 8;

  // Signal-output register fields
  localparam int PGM_BIT_FAST    = 7;
  localparam int PGM_SEL_MSB     = 3;
  localparam int PGM_SEL_LSB     = 0;

  // Mask of the boundary-scan pads
  localparam logic [7:0] PGM_SCAN_MASK = 8'h0f;

  // Monitor source codes
  localparam logic [3:0] PGM_SEL_HIZ_A   = 4'h0;
  localparam logic [3:0] PGM_SEL_HIZ_B   = 4'h1;
  localparam logic [3:0] PGM_SEL_ZERO    = 4'h2;
  localparam logic [3:0] PGM_SEL_ONE     = 4'h3;
  localparam logic [3:0] PGM_SEL_TX_ENV  = 4'h4;
  localparam logic [3:0] PGM_SEL_TX_ACT  = 4'h5;
  localparam logic [3:0] PGM_SEL_SECURE  = 4'h6;
  localparam logic [3:0] PGM_SEL_RX_ENV  = 4'h7;
  localparam logic [3:0] PGM_SEL_RX_ACT  = 4'h8;
  localparam logic [3:0] PGM_SEL_RX_BIT  = 4'h9;

endpackage

/* rtl/pgm_pad_cell.sv */
// Per-pad drive selection for the eight multi-purpose pads.
// Assumes scan and clock functions come from elsewhere in the device.
module pgm_pad_cell (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Control
  input  wire logic [7:0] i_enable,
  input  wire logic [7:0] i_value,
  input  wire logic       i_scan_active,
  // Alternate functions
  input  wire logic [7:0] i_func_out,
  input  wire logic [7:0] i_func_oe,
  // Pads
  output logic      [7:0] o_pad_out,
  output logic      [7:0] o_pad_oe
);

  logic [7:0] out_next;
  logic [7:0] oe_next;
  logic [7:0] out_reg;
  logic [7:0] oe_reg;

  // Per-pad choice between GPIO drive and the pin's own function
  genvar g;
  generate
    for (g = 0; g < pgm_pkg::PGM_NUM_PADS; g++) begin : g_pad
      logic gpio_sel;
      assign gpio_sel = i_enable[g] &&
        !(i_scan_active && pgm_pkg::PGM_SCAN_MASK[g]);
      assign out_next[g] = gpio_sel ? i_value[g] : i_func_out[g];
      assign oe_next[g]  = gpio_sel ? 1'b1 : i_func_oe[g];
    end
  endgenerate

  // Register pad drive
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      out_reg <= 8'h00;
      oe_reg  <= 8'h00;
    end else begin
      out_reg <= out_next;
      oe_reg  <= oe_next;
    end
  end

  assign o_pad_out = out_reg;
  assign o_pad_oe  = oe_reg;

endmodule

/* rtl/pgm_monitor_mux.sv */
// Monitor pin source selector.
// Assumes internal status signals are synchronous to i_clk.
module pgm_monitor_mux (
  // Clock and reset
  input  wire logic       i_clk,
  input  wire logic       i_reset,
  // Selection
  input  wire logic [3:0] i_sel,
  // Internal sources
  input  wire logic       i_tx_envelope,
  input  wire logic       i_tx_active,
  input  wire logic       i_secure_module_serial_signal,
  input  wire logic       i_rx_envelope,
  input  wire logic       i_rx_active,
  input  wire logic       i_rx_bit,
  // Monitor pin
  output logic            o_out,
  output logic            o_oe
);

  logic out_next;
  logic oe_next;
  logic out_reg;
  logic oe_reg;

  // Source selection
  always_comb begin
    out_next = 1'b0;
    oe_next  = 1'b1;
    unique case (i_sel)
      pgm_pkg::PGM_SEL_HIZ_A,
      pgm_pkg::PGM_SEL_HIZ_B: oe_next = 1'b0;
      pgm_pkg::PGM_SEL_ZERO:   out_next = 1'b0;
      pgm_pkg::PGM_SEL_ONE:    out_next = 1'b1;
      pgm_pkg::PGM_SEL_TX_ENV: out_next = i_tx_envelope;
      pgm_pkg::PGM_SEL_TX_ACT: out_next = i_tx_active;
      pgm_pkg::PGM_SEL_SECURE: out_next = i_secure_module_serial_signal;
      pgm_pkg::PGM_SEL_RX_ENV: out_next = i_rx_envelope;
      pgm_pkg::PGM_SEL_RX_ACT: out_next = i_rx_active;
      pgm_pkg::PGM_SEL_RX_BIT: out_next = i_rx_bit;
      default:                 oe_next = 1'b0;
    endcase
  end

  // Register monitor drive
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      out_reg <= 1'b0;
      oe_reg  <= 1'b0;
    end else begin
      out_reg <= out_next;
      oe_reg  <= oe_next;
    end
  end

  assign o_out = out_reg;
  assign o_oe  = oe_reg;

endmodule

/* tb/pgm_top_props.sv */
// Checker for pgm_top: pad drive, readback and monitor pin.
// Bound to every pgm_top; sees its ports only.
module pgm_top_chk (
  // Clock, reset and register port
  input wire logic       i_clk,
  input wire logic       i_reset,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic       i_wr,
  input wire logic       i_rd,
  input wire logic [7:0] o_rdata,
  // Pads
  input wire logic       i_scan_active,
  input wire logic [7:0] i_func_out,
  input wire logic [7:0] i_func_oe,
  input wire logic [7:0] i_pad_in,
  input wire logic [7:0] o_pad_out,
  input wire logic [7:0] o_pad_oe,
  // Monitor
  input wire logic       i_tx_envelope,
  input wire logic       i_tx_active,
  input wire logic       i_secure_module_serial_signal,
  input wire logic       i_rx_envelope,
  input wire logic       i_rx_active,
  input wire logic       i_rx_bit,
  input wire logic       o_monitor_output_pin,
  input wire logic       o_monitor_output_pin_oe,
  input wire logic       o_fast_pad_switching
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] en_reg, en_next, val_reg, val_next, so_reg, so_next;
  logic [7:0] gp, eo, ev;
  logic       mx;
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (i_reset);
  // Shadow copies of the writable registers
  always_comb begin
    en_next = en_reg;
    val_next = val_reg;
    so_next = so_reg;
    if (i_wr && i_addr == 8'h44) en_next = i_wdata;
    if (i_wr && i_addr == 8'h45) val_next = i_wdata;
    if (i_wr && i_addr == 8'h47) so_next = i_wdata & 8'h8f;
  end
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      en_reg <= 8'h00;
      val_reg <= 8'h00;
      so_reg <= 8'h00;
    end else begin
      en_reg <= en_next;
      val_reg <= val_next;
      so_reg <= so_next;
    end
  end
  // Expected pad drive; scan mode keeps the low four pads
  assign gp = en_reg & ~({8{i_scan_active}} & 8'h0f);
  assign eo = gp | i_func_oe;
  assign ev = (gp & val_reg) | (~gp & i_func_out);
  // Expected monitor level; codes 2 and 3 give bit 0
  always_comb begin
    case (so_reg[3:0])
      4'h4: mx = i_tx_envelope;
      4'h5: mx = i_tx_active;
      4'h6: mx = i_secure_module_serial_signal;
      4'h7: mx = i_rx_envelope;
      4'h8: mx = i_rx_active;
      4'h9: mx = i_rx_bit;
      default: mx = so_reg[0];
    endcase
  end
  chk_gpio_upper: assert property (
    !$past(i_reset) |-> o_pad_oe[7:4] == $past(eo[7:4])
      && o_pad_out[7:4] == $past(ev[7:4])) else $error("upper pads");
  chk_scan_gpio: assert property (
    !$past(i_reset) && !$past(i_scan_active) |-> o_pad_oe[3:0] ==
      $past(eo[3:0]) && o_pad_out[3:0] == $past(ev[3:0]))
    else $error("low pads");
  chk_scan_owns: assert property (
    !$past(i_reset) && $past(i_scan_active) |-> o_pad_oe[3:0] ==
      $past(i_func_oe[3:0]) && o_pad_out[3:0] == $past(i_func_out[3:0]))
    else $error("scan pads");
  chk_pad_input: assert property (
    i_rd && i_addr == 8'h46 |=> o_rdata == $past(i_pad_in))
    else $error("pad readback");
  chk_speed_bit: assert property (
    i_wr && i_addr == 8'h47 ##1 !i_wr [*2] |->
      o_fast_pad_switching == $past(i_wdata[7], 2)) else $error("speed");
  chk_mon_hiz: assert property (
    !$past(i_reset) && !($past(so_reg[3:0]) inside {[4'h2:4'h9]}) |->
      !o_monitor_output_pin_oe) else $error("monitor not off");
  chk_mon_const: assert property (
    $past(so_reg[3:1]) == 3'h1 |-> o_monitor_output_pin_oe &&
      o_monitor_output_pin == $past(so_reg[0])) else $error("constant");
  chk_mon_source: assert property (
    $past(so_reg[3:0]) inside {[4'h4:4'h9]} |-> o_monitor_output_pin_oe
      && o_monitor_output_pin == $past(mx)) else $error("source");
  cov_scan_gpio: cover property (i_scan_active && en_reg[3]);
  cov_mon_rx: cover property (so_reg[3:0] == 4'h9);
  cov_pad_read: cover property (i_rd && i_addr == 8'h46);
endmodule

bind pgm_top pgm_top_chk pgm_top_chk_i (.*);

/* tb/pgm_board.sv */
// Board model on the eight multi-purpose pads.
// Assumes no pull resistors: released pads show a moving pattern.
module pgm_board (
  // Clock
  input  wire logic       i_clk,
  // Device drive
  input  wire logic [7:0] i_pad_out,
  input  wire logic [7:0] i_pad_oe,
  // Level seen on the pads
  output logic      [7:0] o_pad_level
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] float_reg = 8'haa;
  // Released pads flip every cycle so a stale value never matches
  always_ff @(posedge i_clk) float_reg <= ~float_reg;
  // Driven pads carry the device value
  assign o_pad_level = (i_pad_oe & i_pad_out) | (~i_pad_oe & float_reg);
endmodule

/* tb/testbench.sv */
// Testbench for pgm_top: register tasks, pad and monitor scenarios.
// Assumes the board model loops the pads back to i_pad_in.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic       i_clk = 1'b0;
  logic       i_reset = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic       i_wr = 1'b0;
  logic       i_rd = 1'b0;
  logic       i_scan_active = 1'b0;
  logic [7:0] i_func_out = 8'h09;
  logic [7:0] i_func_oe = 8'h0c;
  logic [5:0] src = 6'h00;
  logic       i_tx_envelope, i_tx_active, i_secure_module_serial_signal;
  logic       i_rx_envelope, i_rx_active, i_rx_bit, e;
  logic [7:0] i_pad_in, o_rdata, o_pad_out, o_pad_oe;
  logic       o_monitor_output_pin, o_monitor_output_pin_oe;
  logic       o_fast_pad_switching;
  logic [3:0] s;
  int         failures = 0;
  int         n_tests = 0;
  // Monitor sources, transmit envelope in bit 0
  assign {i_rx_bit, i_rx_active, i_rx_envelope} = src[5:3];
  assign {i_secure_module_serial_signal, i_tx_active} = src[2:1];
  assign i_tx_envelope = src[0];
  pgm_top pgm_top_i (.*);
  pgm_board pgm_board_i (.i_clk(i_clk), .i_pad_out(o_pad_out),
    .i_pad_oe(o_pad_oe), .o_pad_level(i_pad_in));
  initial forever #12.5 i_clk = ~i_clk;
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Write at an edge, then one more edge for the pad drive to follow
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_clk);
    i_wr <= 1'b0;
    @(posedge i_clk);
    @(negedge i_clk);
  endtask
  // Read; data stand only in the next cycle, looked at mid-cycle
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge i_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_clk);
    i_rd <= 1'b0;
    @(negedge i_clk);
    check(o_rdata, exp);
  endtask
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge i_clk);
    i_reset <= 1'b0;
    rd(8'h44, 8'h00);
    rd(8'h47, 8'h00);
    rd(8'h40, 8'h00);
    check(o_pad_oe, 8'h0c);
    check(o_pad_out, 8'h09);
    wr(8'h44, 8'hff);
    wr(8'h45, 8'h5a);
    check(o_pad_oe, 8'hff);
    check(o_pad_out, 8'h5a);
    rd(8'h46, 8'h5a);
    @(negedge i_clk);
    check(o_rdata, 8'h00);
    wr(8'h46, 8'h00);
    rd(8'h44, 8'hff);
    @(posedge i_clk);
    i_scan_active <= 1'b1;
    @(posedge i_clk);
    @(negedge i_clk);
    check(o_pad_oe, 8'hfc);
    check(o_pad_out, 8'h59);
    @(posedge i_clk);
    i_scan_active <= 1'b0;
    wr(8'h47, 8'hff);
    check({7'h00, o_fast_pad_switching}, 8'h01);
    rd(8'h47, 8'h8f);
    for (int p = 0; p < 2; p++) begin
      @(posedge i_clk);
      src <= (p == 0) ? 6'h12 : 6'h2d;
      for (int k = 0; k < 16; k++) begin
        s = k[3:0];
        wr(8'h47, {4'h0, s});
        e = (s < 4'h4) ? s[0] : src[s - 4'h4];
        check({7'h00, o_monitor_output_pin_oe},
          {7'h00, s inside {[4'h2:4'h9]}});
        if (s inside {[4'h2:4'h9]})
          check({7'h00, o_monitor_output_pin},
            {7'h00, e});
      end
    end
    check({7'h00, o_fast_pad_switching}, 8'h00);
    print_verdict();
  end
  // Watchdog against a hang
  initial begin
    repeat (2000) @(posedge i_clk);
    failures++;
    print_verdict();
  end
endmodule
